// file: adc_cfg_pkg.sv
/*
  Shared constants and types for the converter configuration bank:
  register offsets, reset values, field positions and carriers.
  Assumes a single 250 MHz clock domain for every user.
*/
package adc_cfg_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int INSTR_BITS = 16;
  localparam int INSTR_RW_BIT = 15;

  localparam logic [ADDR_W-1:0] ADDR_CHAN_INDEX = 13'h005;
  localparam logic [ADDR_W-1:0] ADDR_POWER      = 13'h008;
  localparam logic [ADDR_W-1:0] ADDR_VREF       = 13'h018;
  localparam logic [3:0][ADDR_W-1:0] ADDR_PATTERN = {13'h01C, 13'h01B, 13'h01A, 13'h019};
  localparam logic [ADDR_W-1:0] ADDR_OVERRANGE  = 13'h02A;
  localparam logic [ADDR_W-1:0] ADDR_ASSIGN     = 13'h02E;
  localparam logic [ADDR_W-1:0] ADDR_SYNC       = 13'h03A;
  localparam logic [ADDR_W-1:0] ADDR_TRANSFER   = 13'h0FF;
  localparam logic [ADDR_W-1:0] ADDR_RATE       = 13'h100;
  localparam logic [ADDR_W-1:0] ADDR_PIN_TWO    = 13'h101;
  localparam logic [ADDR_W-1:0] ADDR_PIN_THREE  = 13'h102;

  localparam logic [1:0] RST_CHAN_INDEX = 2'h3;
  localparam logic [2:0] RST_VREF       = 3'h4;
  localparam logic [2:0] VREF_MAX_CODE  = 3'h4;
  localparam logic       RST_OVERRANGE  = 1'h1;
  localparam logic       RST_ASSIGN_A   = 1'h0;
  localparam logic       RST_ASSIGN_B   = 1'h1;
  localparam logic [7:0] RST_PIN_TWO    = 8'h80;

  localparam int PWR_PIN_FUNC_BIT = 5;
  localparam int SYNC_ENABLE_BIT  = 1;
  localparam int SYNC_NEXT_BIT    = 2;
  localparam int TRANSFER_BIT     = 0;
  localparam int RATE_EN_BIT      = 6;
  localparam int RES_LSB          = 3;
  localparam int OEB_EN_BIT       = 7;
  localparam int PULLDOWN_DIS_BIT = 0;
  localparam int CMG_PD_BIT       = 3;

  localparam logic [2:0] RATE_CODE_80  = 3'h3;
  localparam logic [2:0] RATE_CODE_105 = 3'h4;
  localparam logic [2:0] RATE_CODE_125 = 3'h5;
  localparam logic [2:0] RES_CODE_12   = 3'h4;
  localparam logic [2:0] RES_CODE_10   = 3'h6;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0, PM_POWER_DOWN = 2'h1, PM_STANDBY = 2'h2, PM_DIGITAL_RESET = 2'h3
  } power_mode_t;

  typedef enum logic [2:0] {
    SPI_INSTR = 3'h1, SPI_WRITE = 3'h2, SPI_READ = 3'h4
  } spi_state_t;

  typedef struct packed {
    logic datapath_clk_en;
    logic datapath_reset;
    logic outputs_en;
    logic chip_power_down;
  } power_ctrl_t;

  typedef struct packed {
    logic       enable;
    logic [2:0] resolution;
    logic [2:0] rate;
  } rate_override_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_access_t;
endpackage

// file: spi_serial_port.sv
/*
  Serial port slave: 16-bit instruction (read flag, length, 13-bit address)
  then data bytes, MSB first, address stepping down per byte.
  Assumes sclk and chip select are synchronous and slower than clock_in / 4.
*/
module spi_serial_port import adc_cfg_pkg::*; (
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic              sclk_in,
  input  wire logic              ncs_in,
  input  wire logic              sdio_in,
  input  wire logic [DATA_W-1:0] rdata_in,
  output reg_access_t            access_out,
  output logic                   sdio_out,
  output logic                   sdio_oe_out
);
  spi_state_t              state_reg;
  logic                    sclk_reg;
  logic [3:0]              cnt_reg;
  logic [INSTR_BITS-1:0]   shift_reg;
  logic [ADDR_W-1:0]       addr_reg;
  logic [DATA_W-1:0]       wdata_reg;
  logic [DATA_W-1:0]       tx_reg;
  logic                    wr_reg;
  logic                    rd_reg;
  logic                    rise;
  logic                    fall;
  logic                    drive_reg;

  assign rise = sclk_in & ~sclk_reg;
  assign fall = ~sclk_in & sclk_reg;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= sclk_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in || ncs_in) begin
      state_reg <= SPI_INSTR;
      cnt_reg   <= 4'h0;
      shift_reg <= '0;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      wdata_reg <= '0;
      if (!nrst_in) begin
        addr_reg <= '0;
      end
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      // Streaming writes step the address down once the byte is issued
      if (wr_reg) begin
        addr_reg <= addr_reg - 13'h001;
      end
      if (rise) begin
        shift_reg <= {shift_reg[INSTR_BITS-2:0], sdio_in};
        cnt_reg   <= cnt_reg + 4'h1;
        unique case (state_reg)
          SPI_INSTR: begin
            if (cnt_reg == 4'hF) begin
              addr_reg  <= {shift_reg[ADDR_W-2:0], sdio_in};
              cnt_reg   <= 4'h0;
              state_reg <= shift_reg[INSTR_RW_BIT-1] ? SPI_READ : SPI_WRITE;
              rd_reg    <= shift_reg[INSTR_RW_BIT-1];
            end
          end
          SPI_WRITE: begin
            if (cnt_reg == 4'h7) begin
              cnt_reg   <= 4'h0;
              wr_reg    <= 1'b1;
              wdata_reg <= {shift_reg[DATA_W-2:0], sdio_in};
            end
          end
          SPI_READ: begin
            if (cnt_reg == 4'h7) begin
              cnt_reg  <= 4'h0;
              addr_reg <= addr_reg - 13'h001;
              rd_reg   <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Read data loaded one cycle after the request, ahead of the next falling edge
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      tx_reg   <= '0;
      sdio_out <= 1'b0;
    end else if (rd_reg) begin
      tx_reg <= rdata_in;
    end else if (fall && state_reg == SPI_READ) begin
      sdio_out <= tx_reg[DATA_W-1];
      tx_reg   <= {tx_reg[DATA_W-2:0], 1'b0};
    end
  end

  // Drive only after the first fall of the read, once the host has let go
  always_ff @(posedge clock_in) begin
    if (!nrst_in || ncs_in) begin
      drive_reg <= 1'b0;
    end else if (fall && state_reg == SPI_READ) begin
      drive_reg <= 1'b1;
    end
  end

  assign sdio_oe_out = drive_reg & ~ncs_in;
  assign access_out  = '{wr: wr_reg, rd: rd_reg, addr: addr_reg, wdata: wdata_reg};
endmodule // spi_serial_port

// file: divider_sync_gate.sv
/*
  Clock divider sync gating with the one-shot option.
  Assumes sync_in is a one-cycle pulse synchronous to clock_in.
*/
module divider_sync_gate import adc_cfg_pkg::*; (
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic              sync_in,
  input  wire logic              write_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic                   sync_enable_out,
  output logic                   next_only_out,
  output logic                   divider_sync_out
);
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sync_enable_out <= 1'b0;
      next_only_out   <= 1'b0;
    end else if (write_in) begin
      // A host write wins over the automatic clear
      sync_enable_out <= wdata_in[SYNC_ENABLE_BIT];
      next_only_out   <= wdata_in[SYNC_NEXT_BIT];
    end else if (sync_in && sync_enable_out && next_only_out) begin
      sync_enable_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      divider_sync_out <= 1'b0;
    end else begin
      divider_sync_out <= sync_in & sync_enable_out;
    end
  end

  sequence one_shot_sync_s;
    sync_in && sync_enable_out && next_only_out && !write_in;
  endsequence

  sequence passed_then_closed_s;
    divider_sync_out && !sync_enable_out;
  endsequence

  one_shot_sync_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    one_shot_sync_s |=> passed_then_closed_s)
    else $error("one-shot sync did not pass once and close");

  sync_gated_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !sync_enable_out |=> !divider_sync_out)
    else $error("sync pulse passed while gate closed");
endmodule // divider_sync_gate

// file: adc_config_regs.sv
/*
  Configuration register bank and power-mode control of a dual converter,
  reached over the serial port. Drives mode, reference span, patterns,
  overrange, output assignment, sync gating, rate override and pin controls.
  Assumes serial pins and sync_in are synchronous to clock_in.
*/
module adc_config_regs import adc_cfg_pkg::*; #(
  parameter logic [2:0] SPEED_GRADE_CODE = RATE_CODE_125
) (
  input  wire logic   clock_in,
  input  wire logic   nrst_in,
  input  wire logic   sclk_in,
  input  wire logic   ncs_in,
  input  wire logic   sdio_in,
  output logic        sdio_out,
  output logic        sdio_oe_out,
  input  wire logic   power_down_pin_in,
  input  wire logic   output_disable_pin_in,
  input  wire logic   sync_in,
  output power_ctrl_t power_ctrl_out,
  output logic [2:0]  vref_code_out,
  output logic [15:0] pattern_one_out,
  output logic [15:0] pattern_two_out,
  output logic        overrange_en_out,
  output logic        assign_a_out,
  output logic        assign_b_out,
  output logic        divider_sync_out,
  output rate_override_t rate_override_out,
  output logic        sdio_pulldown_en_out,
  output logic        common_mode_generator_pd_out
);
  generate
    if (SPEED_GRADE_CODE < RATE_CODE_80 || SPEED_GRADE_CODE > RATE_CODE_125) begin : g_bad
      $error("SPEED_GRADE_CODE outside the supported rate codes");
    end
  endgenerate

  function automatic logic hit(input reg_access_t a, input logic [ADDR_W-1:0] off);
    return a.wr && (a.addr == off);
  endfunction

  reg_access_t         acc;
  logic [DATA_W-1:0]   rdata;
  logic [1:0]          chan_index_reg;
  power_mode_t         pwr_mode_reg;
  logic                pin_func_reg;
  logic [7:0]          pattern_reg [4];
  logic                oeb_pin_en_reg;
  logic                pulldown_dis_reg;
  rate_override_t      rate_staged_reg;
  logic                sync_enable;
  logic                sync_next_only;
  logic                too_fast;
  power_mode_t         mode_eff;
  power_ctrl_t         ctrl_next;

  ////////////////////////////////////////////////////////////////////////////
  spi_serial_port u_port (
    .clock_in    (clock_in),
    .nrst_in     (nrst_in),
    .sclk_in     (sclk_in),
    .ncs_in      (ncs_in),
    .sdio_in     (sdio_in),
    .rdata_in    (rdata),
    .access_out  (acc),
    .sdio_out    (sdio_out),
    .sdio_oe_out (sdio_oe_out)
  );

  divider_sync_gate u_sync (
    .clock_in         (clock_in),
    .nrst_in          (nrst_in),
    .sync_in          (sync_in),
    .write_in         (hit(acc, ADDR_SYNC)),
    .wdata_in         (acc.wdata),
    .sync_enable_out  (sync_enable),
    .next_only_out    (sync_next_only),
    .divider_sync_out (divider_sync_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Writable fields take effect the cycle after the write strobe
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      chan_index_reg <= RST_CHAN_INDEX;
    end else if (hit(acc, ADDR_CHAN_INDEX)) begin
      chan_index_reg <= acc.wdata[1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pwr_mode_reg <= PM_NORMAL;
      pin_func_reg <= 1'b0;
    end else if (hit(acc, ADDR_POWER)) begin
      pwr_mode_reg <= power_mode_t'(acc.wdata[1:0]);
      pin_func_reg <= acc.wdata[PWR_PIN_FUNC_BIT];
    end
  end

  // Codes above the largest span are refused so the field stays legal
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      vref_code_out <= RST_VREF;
    end else if (hit(acc, ADDR_VREF) && acc.wdata[2:0] <= VREF_MAX_CODE) begin
      vref_code_out <= acc.wdata[2:0];
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_pattern
      always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
          pattern_reg[i] <= '0;
        end else if (hit(acc, ADDR_PATTERN[i])) begin
          pattern_reg[i] <= acc.wdata;
        end
      end
    end
  endgenerate

  assign pattern_one_out = {pattern_reg[1], pattern_reg[0]};
  assign pattern_two_out = {pattern_reg[3], pattern_reg[2]};

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      overrange_en_out <= RST_OVERRANGE;
    end else if (hit(acc, ADDR_OVERRANGE)) begin
      overrange_en_out <= acc.wdata[0];
    end
  end

  // Assignment is per channel: a write lands in every selected channel
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      assign_a_out <= RST_ASSIGN_A;
      assign_b_out <= RST_ASSIGN_B;
    end else if (hit(acc, ADDR_ASSIGN)) begin
      if (chan_index_reg[0]) begin
        assign_a_out <= acc.wdata[0];
      end
      if (chan_index_reg[1]) begin
        assign_b_out <= acc.wdata[0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      oeb_pin_en_reg   <= RST_PIN_TWO[OEB_EN_BIT];
      pulldown_dis_reg <= RST_PIN_TWO[PULLDOWN_DIS_BIT];
    end else if (hit(acc, ADDR_PIN_TWO)) begin
      oeb_pin_en_reg   <= acc.wdata[OEB_EN_BIT];
      pulldown_dis_reg <= acc.wdata[PULLDOWN_DIS_BIT];
    end
  end

  assign sdio_pulldown_en_out = ~pulldown_dis_reg;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      common_mode_generator_pd_out <= 1'b0;
    end else if (hit(acc, ADDR_PIN_THREE)) begin
      common_mode_generator_pd_out <= acc.wdata[CMG_PD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate override is staged; only the transfer strobe moves it live
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rate_staged_reg <= '0;
    end else if (hit(acc, ADDR_RATE)) begin
      rate_staged_reg <= '{enable:     acc.wdata[RATE_EN_BIT],
                           resolution: acc.wdata[RES_LSB +: 3],
                           rate:       acc.wdata[2:0]};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rate_override_out <= '0;
    end else if (hit(acc, ADDR_TRANSFER) && acc.wdata[TRANSFER_BIT]) begin
      rate_override_out <= rate_staged_reg;
    end
  end

  // Asking for more than the grade shuts the chip rather than overclock it
  assign too_fast = rate_override_out.enable &&
                    (rate_override_out.rate > SPEED_GRADE_CODE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mode_eff = pwr_mode_reg;
    if (power_down_pin_in) begin
      mode_eff = pin_func_reg ? PM_POWER_DOWN : PM_STANDBY;
    end
    if (too_fast) begin
      mode_eff = PM_POWER_DOWN;
    end
  end

  always_comb begin
    ctrl_next = '0;
    unique case (mode_eff)
      PM_NORMAL: begin
        ctrl_next.datapath_clk_en = 1'b1;
        ctrl_next.outputs_en      = 1'b1;
      end
      PM_POWER_DOWN: begin
        ctrl_next.datapath_reset  = 1'b1;
        ctrl_next.chip_power_down = 1'b1;
      end
      PM_STANDBY: begin
        ctrl_next.datapath_reset  = 1'b0;
      end
      PM_DIGITAL_RESET: begin
        ctrl_next.datapath_reset  = 1'b1;
        ctrl_next.outputs_en      = 1'b1;
      end
    endcase
    // External output-disable pin only counts while enabled
    if (oeb_pin_en_reg && output_disable_pin_in) begin
      ctrl_next.outputs_en = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      power_ctrl_out <= '{datapath_clk_en: 1'b1, datapath_reset: 1'b0,
                          outputs_en: 1'b1, chip_power_down: 1'b0};
    end else begin
      power_ctrl_out <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata = '0;
    unique case (acc.addr)
      ADDR_CHAN_INDEX: rdata[1:0] = chan_index_reg;
      ADDR_POWER: begin
        rdata[1:0]             = pwr_mode_reg;
        rdata[PWR_PIN_FUNC_BIT] = pin_func_reg;
      end
      ADDR_VREF:       rdata[2:0] = vref_code_out;
      ADDR_PATTERN[0]: rdata = pattern_reg[0];
      ADDR_PATTERN[1]: rdata = pattern_reg[1];
      ADDR_PATTERN[2]: rdata = pattern_reg[2];
      ADDR_PATTERN[3]: rdata = pattern_reg[3];
      ADDR_OVERRANGE:  rdata[0] = overrange_en_out;
      ADDR_ASSIGN:     rdata[0] = chan_index_reg[0] ? assign_a_out : assign_b_out;
      ADDR_SYNC: begin
        rdata[SYNC_ENABLE_BIT] = sync_enable;
        rdata[SYNC_NEXT_BIT]   = sync_next_only;
      end
      ADDR_RATE: begin
        rdata[RATE_EN_BIT]    = rate_staged_reg.enable;
        rdata[RES_LSB +: 3]   = rate_staged_reg.resolution;
        rdata[2:0]            = rate_staged_reg.rate;
      end
      ADDR_PIN_TWO: begin
        rdata[OEB_EN_BIT]       = oeb_pin_en_reg;
        rdata[PULLDOWN_DIS_BIT] = pulldown_dis_reg;
      end
      ADDR_PIN_THREE:  rdata[CMG_PD_BIT] = common_mode_generator_pd_out;
      default:         rdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  logic oe_gate;
  assign oe_gate = oeb_pin_en_reg && output_disable_pin_in;

  sequence staged_rate_write_s;
    hit(acc, ADDR_RATE) && !hit(acc, ADDR_TRANSFER);
  endsequence

  normal_mode_a: assert property (mode_eff == PM_NORMAL && !oe_gate |=>
    power_ctrl_out.datapath_clk_en && !power_ctrl_out.datapath_reset && power_ctrl_out.outputs_en)
    else $error("normal mode did not run the data path");
  power_down_a: assert property (mode_eff == PM_POWER_DOWN |=>
    !power_ctrl_out.datapath_clk_en && power_ctrl_out.datapath_reset && !power_ctrl_out.outputs_en)
    else $error("power-down mode state wrong");
  standby_mode_a: assert property (mode_eff == PM_STANDBY |=>
    !power_ctrl_out.datapath_clk_en && !power_ctrl_out.datapath_reset && !power_ctrl_out.outputs_en)
    else $error("standby mode state wrong");
  digital_reset_a: assert property (mode_eff == PM_DIGITAL_RESET && !oe_gate |=>
    !power_ctrl_out.datapath_clk_en && power_ctrl_out.datapath_reset && power_ctrl_out.outputs_en)
    else $error("digital reset state wrong");
  pin_function_a: assert property (power_down_pin_in && !pin_func_reg && !too_fast |=>
    !power_ctrl_out.chip_power_down && !power_ctrl_out.datapath_reset)
    else $error("pin did not select standby");
  vref_range_a: assert property (vref_code_out <= VREF_MAX_CODE)
    else $error("span code outside legal range");
  pattern_write_a: assert property (hit(acc, ADDR_PATTERN[1]) |=>
    pattern_one_out[15:8] == $past(acc.wdata))
    else $error("pattern high byte not stored");
  overrange_write_a: assert property (hit(acc, ADDR_OVERRANGE) |=>
    overrange_en_out == $past(acc.wdata[0]))
    else $error("overrange enable not stored");
  override_staged_a: assert property (staged_rate_write_s |=>
    rate_override_out == $past(rate_override_out))
    else $error("override applied without transfer");
  too_fast_a: assert property (too_fast |=> power_ctrl_out.chip_power_down)
    else $error("overclock request did not power down");
endmodule // adc_config_regs

// file: spi_host_model.sv
/*
  Host model for the serial configuration port: frames 24-bit transfers.
  Assumes the bench resolves the shared data wire from both enables.
*/
module spi_host_model (
  input  wire logic clock_in,
  input  wire logic sdio_wire_in,
  output logic      sclk_out,
  output logic      ncs_out,
  output logic      sdio_drv_out,
  output logic      sdio_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock cycles per serial phase; raise it to act as a slow host
  int phase = 5;
  initial begin
    sclk_out = 1'b0;
    ncs_out = 1'b1;
    sdio_drv_out = 1'b0;
    sdio_oe_out = 1'b0;
  end
  task automatic half();
    repeat (phase) @(posedge clock_in);
    #1;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                      output logic [7:0] rdv);
    logic [23:0] sh;
    sh = {rd, 2'h0, addr, wd};
    rdv = 8'h00;
    ncs_out = 1'b0;
    sdio_oe_out = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      // Let go of the wire before the device starts answering
      if (rd && i < 8) sdio_oe_out = 1'b0;
      sdio_drv_out = sh[i];
      half();
      sclk_out = 1'b1;
      if (i < 8) rdv[i] = sdio_wire_in;
      half();
      sclk_out = 1'b0;
    end
    half();
    ncs_out = 1'b1;
    sdio_oe_out = 1'b0;
    half();
  endtask
endmodule // spi_host_model

// file: tb.sv
/*
  Self-checking bench for the configuration bank, driven over the serial port.
  Assumes the host model frames every access.
*/
module tb;
  import adc_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0, nrst_in = 1'b0, pd_pin = 1'b0, oeb_pin = 1'b0, sync = 1'b0;
  logic sclk, ncs, h_drv, h_oe, sdio_out, sdio_oe, sdio_wire, ovr, asg_a, asg_b, dsync;
  logic pden, cmgpd;
  logic [2:0] vref;
  logic [15:0] pat1, pat2;
  power_ctrl_t pc;
  rate_override_t rov;
  int fail_count = 0, comparisons = 0, cycles = 0;
  localparam logic [12:0] RA [11] = '{13'h018, 13'h019, 13'h01A, 13'h01B, 13'h01C,
    13'h02A, 13'h02E, 13'h03A, 13'h100, 13'h101, 13'h102};
  localparam logic [7:0] RV [11] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h80, 8'h00};
  localparam logic [2:0] PEXP [4] = '{3'b101, 3'b010, 3'b000, 3'b011};
  always #2 clock_in = ~clock_in;
  // Released wire falls to the pull-down, or flips when that is off
  assign sdio_wire = sdio_oe ? sdio_out : h_oe ? h_drv : (pden ? 1'b0 : ~h_drv);
  spi_host_model u_spi_host_model (.clock_in(clock_in), .sdio_wire_in(sdio_wire),
    .sclk_out(sclk), .ncs_out(ncs), .sdio_drv_out(h_drv), .sdio_oe_out(h_oe));
  adc_config_regs #(.SPEED_GRADE_CODE(RATE_CODE_105)) u_adc_config_regs (
    .clock_in(clock_in), .nrst_in(nrst_in), .sclk_in(sclk), .ncs_in(ncs),
    .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe),
    .power_down_pin_in(pd_pin), .output_disable_pin_in(oeb_pin), .sync_in(sync),
    .power_ctrl_out(pc), .vref_code_out(vref), .pattern_one_out(pat1),
    .pattern_two_out(pat2), .overrange_en_out(ovr), .assign_a_out(asg_a),
    .assign_b_out(asg_b), .divider_sync_out(dsync), .rate_override_out(rov),
    .sdio_pulldown_en_out(pden), .common_mode_generator_pd_out(cmgpd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_spi_host_model.xfer(1'b0, a, d, unused);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_spi_host_model.xfer(1'b1, a, 8'h00, got);
    chk({8'h00, got}, {8'h00, exp});
  endtask
  task automatic pulse(input logic exp);
    sync = 1'b1;
    tick(1);
    sync = 1'b0;
    chk({15'h0, dsync}, {15'h0, exp});
    tick(2);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    nrst_in = 1'b1;
    tick(2);
    foreach (RA[i]) rd_chk(RA[i], RV[i]);
    chk({13'h0, vref}, 16'h0004);
    $display("reset values done");
    wr(ADDR_VREF, 8'h03);
    chk({13'h0, vref}, 16'h0003);
    wr(ADDR_VREF, 8'h05);
    rd_chk(ADDR_VREF, 8'h03);
    wr(13'h019, 8'hA5);
    wr(13'h01A, 8'h3C);
    wr(13'h01B, 8'h0F);
    wr(13'h01C, 8'hF0);
    chk(pat1, 16'h3CA5);
    chk(pat2, 16'hF00F);
    wr(ADDR_OVERRANGE, 8'hFE);
    chk({15'h0, ovr}, 16'h0000);
    rd_chk(ADDR_OVERRANGE, 8'h00);
    wr(ADDR_PIN_THREE, 8'hFF);
    chk({15'h0, cmgpd}, 16'h0001);
    rd_chk(ADDR_PIN_THREE, 8'h08);
    $display("field access done");
    wr(ADDR_PIN_TWO, 8'h01);
    oeb_pin = 1'b1;
    tick(3);
    chk({14'h0, pden, pc.outputs_en}, 16'h0001);
    wr(ADDR_PIN_TWO, 8'hFF);
    chk({15'h0, pc.outputs_en}, 16'h0000);
    rd_chk(ADDR_PIN_TWO, 8'h81);
    oeb_pin = 1'b0;
    $display("pin control done");
    wr(ADDR_CHAN_INDEX, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_POWER, 8'(m));
      chk({13'h0, pc[3:1]}, {13'h0, PEXP[m]});
    end
    wr(ADDR_POWER, 8'h20);
    pd_pin = 1'b1;
    tick(3);
    chk({13'h0, pc[3:1]}, 16'h0002);
    wr(ADDR_POWER, 8'h00);
    chk({13'h0, pc[3:1]}, 16'h0000);
    pd_pin = 1'b0;
    tick(3);
    chk({13'h0, pc[3:1]}, 16'h0005);
    $display("power modes done");
    wr(ADDR_CHAN_INDEX, 8'h01);
    wr(ADDR_ASSIGN, 8'h01);
    chk({14'h0, asg_a, asg_b}, 16'h0003);
    wr(ADDR_CHAN_INDEX, 8'h02);
    wr(ADDR_ASSIGN, 8'h00);
    chk({14'h0, asg_a, asg_b}, 16'h0002);
    $display("output assign done");
    wr(ADDR_SYNC, 8'h02);
    pulse(1'b1);
    pulse(1'b1);
    wr(ADDR_SYNC, 8'h06);
    pulse(1'b1);
    pulse(1'b0);
    rd_chk(ADDR_SYNC, 8'h04);
    $display("sync done");
    u_spi_host_model.phase = 9;
    wr(ADDR_RATE, 8'h63);
    chk({9'h0, rov}, 16'h0000);
    rd_chk(ADDR_RATE, 8'h63);
    wr(ADDR_TRANSFER, 8'h01);
    chk({9'h0, rov}, 16'h0063);
    chk({15'h0, pc.chip_power_down}, 16'h0000);
    wr(ADDR_RATE, 8'h75);
    wr(ADDR_TRANSFER, 8'h01);
    chk({9'h0, rov}, 16'h0075);
    chk({15'h0, pc.chip_power_down}, 16'h0001);
    $display("rate override done");
    end_of_test();
  end
endmodule // tb
